// File: verilog/selftest_consts.svh
// Offsets, field positions, codes, lamp patterns and last test numbers of the self-test phases.
`ifndef SELFTEST_CONSTS_SVH
`define SELFTEST_CONSTS_SVH
`define INIT_POLL_OFFSET 4'h0
`define PORT_STATUS_OFFSET 4'h2
`define STATUS_FATAL_BIT 15
`define STATUS_PHASE1_BIT 14
`define STATUS_PHASE2_BIT 13
`define CODE_NO_INFO 8'h00
`define CODE_PKT_READ 8'h01
`define CODE_PKT_WRITE 8'h02
`define CODE_CTRL_RAM 8'h04
`define CODE_CTRL_CHECKSUM 8'h05
`define CODE_RING_READ 8'h06
`define CODE_RING_WRITE 8'h07
`define CODE_HOST_TIMEOUT 8'h09
`define CODE_CMD_OVERFLOW 8'h0a
`define CODE_DMA_FAIL 8'h0b
`define CODE_CTRL_FATAL 8'h0c
`define CODE_BAD_CONN_ID 8'h0e
`define CODE_INIT_SEQ 8'h13
`define LAMPS_OFF 3'h0
`define LAMPS_PRETEST_PASS 3'h4
`define LAMPS_FATAL 3'h7
`define LAMPS_CPU_FAIL 3'h1
`define LAMPS_BUSCHIP_FAIL 3'h2
`define LAMPS_IDLE 3'h4
`define LAMPS_BUFFER_FAIL 3'h3
`define LAMPS_ADAPTER_FAIL 3'h5
`define LAMPS_PROM_FAIL 3'h6
`define PHASE1_LAST 3'h1
`define PHASE2_LAST 3'h5
`endif

// File: verilog/selftest_pkg.sv
// Types shared by the self-test sequencer and its bench.
package selftest_pkg;
  typedef enum logic [2:0] {
    ST_PHASE1 = 3'h0,
    ST_AWAIT_INIT = 3'h1,
    ST_PHASE2 = 3'h2,
    ST_RUNNING = 3'h3,
    ST_HALTED = 3'h4,
    ST_FATAL = 3'h5
  } state_e;
  typedef enum logic [2:0] {
    TEST_CPU = 3'h0,
    TEST_BUSCHIP = 3'h1,
    TEST_BUFFER = 3'h2,
    TEST_ADAPTER = 3'h3,
    TEST_REFRESH = 3'h4,
    TEST_PROM = 3'h5
  } test_id_e;
  typedef enum logic [3:0] {
    FK_NO_INFO = 4'h0,
    FK_PKT_READ = 4'h1,
    FK_PKT_WRITE = 4'h2,
    FK_RING_READ = 4'h3,
    FK_RING_WRITE = 4'h4,
    FK_HOST_TIMEOUT = 4'h5,
    FK_CMD_OVERFLOW = 4'h6,
    FK_DMA_FAIL = 4'h7,
    FK_BAD_CONN_ID = 4'h8,
    FK_INIT_SEQ = 4'h9,
    FK_CTRL_FATAL = 4'ha
  } fault_kind_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] offset;
    logic [15:0] wdata;
  } reg_access_s;
  typedef struct packed {
    logic done;
    logic fail;
  } test_result_s;
endpackage : selftest_pkg

// File: verilog/selftest_fault_reporter.sv
// Power-up self-test sequencer, lamp driver and fatal code reporter.
`timescale 1ns/100ps
`include "selftest_consts.svh"

// Overview of operation
// - Restart phase one on reset, init, poll write.
// - Phase one pass lights pretest pass lamp.
// - Diagnostic lamp codes only with switch on.
// - Diagnostic mode halts, holds failing test code.
// - Distinct patterns: processor, bus chip, idle.
// - Patterns for buffer, adapter, PROM; off passes.
// - Phase two runs during host initialization.
// - Initialization errors reported in status register.
// - Fatal lights all lamps, code in low byte.
// - Codes 1, 2, 6 for packet read, packet write, ring read.
// - Code 7 for ring envelope write error.
// - Codes 4, 5, 14 for self-test failures.
// - Code 11 for host timeout.
// - Code 12 command overflow, 13 DMA failure.
// - Codes 16, 23, 0 for connection, init, none.
// - Any init/poll write forces hard initialization.
module selftest_fault_reporter (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_B,
  // System bus initialization pulse and diagnostic switch level.
  input wire logic BUS_INIT,
  input wire logic DIAG_DISPLAY_SWITCH,
  // Word register access from the host.
  input wire selftest_pkg::reg_access_s REG_ACCESS,
  output logic [15:0] REG_RDATA,
  // Host initialization sequence has begun.
  input wire logic HOST_INIT_START,
  // Test engine handshake.
  output logic TEST_REQ,
  output selftest_pkg::test_id_e TEST_ID,
  input wire selftest_pkg::test_result_s TEST_RESULT,
  // Fatal fault report from the running server.
  input wire logic FAULT_VALID,
  input wire selftest_pkg::fault_kind_e FAULT_KIND,
  // Lamps {pretest pass lamp, lamp 2, lamp 1} and processor halt.
  output logic [2:0] LAMPS,
  output logic CPU_HALT
);

  logic rst_meta;
  logic rst_sync;
  selftest_pkg::state_e state;
  selftest_pkg::state_e next_state;
  selftest_pkg::test_id_e test_id;
  selftest_pkg::test_id_e next_test_id;
  logic test_req;
  logic next_test_req;
  logic busy;
  logic next_busy;
  logic diag_mode;
  logic next_diag_mode;
  logic [2:0] lamps;
  logic [2:0] next_lamps;
  logic [7:0] code;
  logic [7:0] next_code;
  logic fatal;
  logic next_fatal;
  logic phase1_done;
  logic next_phase1_done;
  logic phase2_done;
  logic next_phase2_done;
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic cpu_halt;
  logic next_cpu_halt;
  logic restart;
  logic [7:0] fault_code;
  logic [7:0] test_code;
  logic [2:0] test_lamps;

  // Reset is released through two flip-flops.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // A bus init or any word written to the poll register restarts.
  assign restart = BUS_INIT | (REG_ACCESS.wr &
    (REG_ACCESS.offset == `INIT_POLL_OFFSET));

  // Running faults map onto the fatal codes posted to the host.
  always_comb begin
    case (FAULT_KIND)
      selftest_pkg::FK_PKT_READ: fault_code = `CODE_PKT_READ;
      selftest_pkg::FK_PKT_WRITE: fault_code = `CODE_PKT_WRITE;
      selftest_pkg::FK_RING_READ: fault_code = `CODE_RING_READ;
      selftest_pkg::FK_RING_WRITE: fault_code = `CODE_RING_WRITE;
      selftest_pkg::FK_HOST_TIMEOUT: fault_code = `CODE_HOST_TIMEOUT;
      selftest_pkg::FK_CMD_OVERFLOW: fault_code = `CODE_CMD_OVERFLOW;
      selftest_pkg::FK_DMA_FAIL: fault_code = `CODE_DMA_FAIL;
      selftest_pkg::FK_BAD_CONN_ID: fault_code = `CODE_BAD_CONN_ID;
      selftest_pkg::FK_INIT_SEQ: fault_code = `CODE_INIT_SEQ;
      selftest_pkg::FK_CTRL_FATAL: fault_code = `CODE_CTRL_FATAL;
      default: fault_code = `CODE_NO_INFO;
    endcase
  end

  // Each test maps to a diagnostic lamp code and a fatal code; buffer and refresh share both.
  always_comb begin
    case (test_id)
      selftest_pkg::TEST_CPU: begin
        test_lamps = `LAMPS_CPU_FAIL;
        test_code = `CODE_CTRL_FATAL;
      end
      selftest_pkg::TEST_BUSCHIP: begin
        test_lamps = `LAMPS_BUSCHIP_FAIL;
        test_code = `CODE_CTRL_FATAL;
      end
      selftest_pkg::TEST_BUFFER, selftest_pkg::TEST_REFRESH: begin
        test_lamps = `LAMPS_BUFFER_FAIL;
        test_code = `CODE_CTRL_RAM;
      end
      selftest_pkg::TEST_ADAPTER: begin
        test_lamps = `LAMPS_ADAPTER_FAIL;
        test_code = `CODE_CTRL_FATAL;
      end
      default: begin
        test_lamps = `LAMPS_PROM_FAIL;
        test_code = `CODE_CTRL_CHECKSUM;
      end
    endcase
  end

  // Sequencer next state, lamps, status word and test handshake.
  always_comb begin
    next_state = state;
    next_test_id = test_id;
    next_test_req = 1'b0;
    next_busy = busy;
    next_diag_mode = diag_mode;
    next_lamps = lamps;
    next_code = code;
    next_fatal = fatal;
    next_phase1_done = phase1_done;
    next_phase2_done = phase2_done;
    if (restart) begin
      // Switch is taken only here, so a change needs a restart.
      next_diag_mode = DIAG_DISPLAY_SWITCH;
      next_state = selftest_pkg::ST_PHASE1;
      next_test_id = selftest_pkg::TEST_CPU;
      next_test_req = 1'b1;
      next_busy = 1'b1;
      next_lamps = `LAMPS_OFF;
      next_code = `CODE_NO_INFO;
      next_fatal = 1'b0;
      next_phase1_done = 1'b0;
      next_phase2_done = 1'b0;
      if (FAULT_VALID) begin
        // A fault in the restart cycle is kept rather than lost.
        next_state = selftest_pkg::ST_FATAL;
        next_test_req = 1'b0;
        next_busy = 1'b0;
        next_fatal = 1'b1;
        next_code = fault_code;
        next_lamps = `LAMPS_FATAL;
      end
    end else begin
      case (state)
        selftest_pkg::ST_PHASE1, selftest_pkg::ST_PHASE2: begin
          if (busy && TEST_RESULT.done) begin
            next_busy = 1'b0;
            if (TEST_RESULT.fail) begin
              if (diag_mode) begin
                next_state = selftest_pkg::ST_HALTED;
                next_lamps = test_lamps;
              end else begin
                next_state = selftest_pkg::ST_FATAL;
                next_lamps = `LAMPS_FATAL;
              end
              next_fatal = 1'b1;
              next_code = test_code;
            end else if (state == selftest_pkg::ST_PHASE1 &&
                         test_id == `PHASE1_LAST) begin
              next_state = selftest_pkg::ST_AWAIT_INIT;
              next_phase1_done = 1'b1;
              // The idle pattern is the third lamp alone in both modes.
              next_lamps = `LAMPS_PRETEST_PASS;
            end else if (test_id == `PHASE2_LAST) begin
              next_state = selftest_pkg::ST_RUNNING;
              next_phase2_done = 1'b1;
              next_lamps = `LAMPS_OFF;
            end else begin
              next_test_id = selftest_pkg::test_id_e'(test_id + 3'h1);
              next_test_req = 1'b1;
              next_busy = 1'b1;
            end
          end
        end
        selftest_pkg::ST_AWAIT_INIT: begin
          if (HOST_INIT_START) begin
            next_state = selftest_pkg::ST_PHASE2;
            next_test_id = selftest_pkg::TEST_BUFFER;
            next_test_req = 1'b1;
            next_busy = 1'b1;
          end
        end
        default: begin
        end
      endcase
      // First fatal fault wins; later ones leave code and lamps alone.
      if (FAULT_VALID && !next_fatal) begin
        next_state = selftest_pkg::ST_FATAL;
        next_test_req = 1'b0;
        next_busy = 1'b0;
        next_fatal = 1'b1;
        next_code = fault_code;
        next_lamps = `LAMPS_FATAL;
      end
    end
    // The halt output follows the halted state from its own flip-flop.
    next_cpu_halt = (next_state == selftest_pkg::ST_HALTED);
  end

  // Status word read data; the poll register reads as zero.
  always_comb begin
    next_rdata = rdata;
    if (REG_ACCESS.rd) begin
      next_rdata = 16'h0000;
      if (REG_ACCESS.offset == `PORT_STATUS_OFFSET) begin
        next_rdata[`STATUS_FATAL_BIT] = fatal;
        next_rdata[`STATUS_PHASE1_BIT] = phase1_done;
        next_rdata[`STATUS_PHASE2_BIT] = phase2_done;
        next_rdata[7:0] = code;
      end
    end
  end

  // Register all sequencer state.
  always_ff @(posedge MCLK or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= selftest_pkg::ST_PHASE1;
      test_id <= selftest_pkg::TEST_CPU;
      test_req <= 1'b1;
      busy <= 1'b1;
      diag_mode <= 1'b0;
      lamps <= `LAMPS_OFF;
      code <= `CODE_NO_INFO;
      fatal <= 1'b0;
      phase1_done <= 1'b0;
      phase2_done <= 1'b0;
      rdata <= 16'h0000;
      cpu_halt <= 1'b0;
    end else begin
      state <= next_state;
      test_id <= next_test_id;
      test_req <= next_test_req;
      busy <= next_busy;
      diag_mode <= next_diag_mode;
      lamps <= next_lamps;
      code <= next_code;
      fatal <= next_fatal;
      phase1_done <= next_phase1_done;
      phase2_done <= next_phase2_done;
      rdata <= next_rdata;
      cpu_halt <= next_cpu_halt;
    end
  end

  // Outputs come straight from the flip-flops.
  assign REG_RDATA = rdata;
  assign TEST_REQ = test_req;
  assign TEST_ID = test_id;
  assign LAMPS = lamps;
  assign CPU_HALT = cpu_halt;

endmodule : selftest_fault_reporter

// File: bench/selftest_fault_reporter_asserts.sv
// Concurrent checks on the ports of the self-test reporter.
`timescale 1ns/100ps
module selftest_chk (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_B,
  // Inputs of the block.
  input wire logic BUS_INIT,
  input wire selftest_pkg::reg_access_s REG_ACCESS,
  input wire selftest_pkg::test_result_s TEST_RESULT,
  input wire logic FAULT_VALID,
  // Outputs of the block.
  input wire logic [15:0] REG_RDATA,
  input wire logic TEST_REQ,
  input wire selftest_pkg::test_id_e TEST_ID,
  input wire logic [2:0] LAMPS,
  input wire logic CPU_HALT
);
  logic [2:0] up;
  logic bz;
  logic go;
  logic rs;
  logic ft;
  logic ok;
  // Age since reset and a test-in-flight flag, cleared by any restart.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      up <= 3'h0;
      bz <= 1'b0;
    end else begin
      if (up != 3'h4) up <= up + 3'h1;
      if (rs) bz <= 1'b0;
      else if (TEST_REQ) bz <= 1'b1;
      else if (TEST_RESULT.done) bz <= 1'b0;
    end
  end
  // Checks wait for the internal reset copy to be released.
  assign go = (up == 3'h4);
  assign rs = BUS_INIT || (REG_ACCESS.wr && REG_ACCESS.offset == 4'h0);
  assign ft = (LAMPS == 3'h7) || CPU_HALT;
  assign ok = go && bz && TEST_RESULT.done && !TEST_RESULT.fail && !rs &&
    !FAULT_VALID && !ft;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  sequence s_pass(logic [2:0] id);
    ok && TEST_ID == id;
  endsequence
  sequence s_restart;
    go && rs && !FAULT_VALID;
  endsequence
  a_next_test: assert property ((s_pass(3'h0) or s_pass(3'h2) or
    s_pass(3'h3) or s_pass(3'h4)) |=>
    TEST_REQ && TEST_ID == $past(TEST_ID) + 3'h1) else $error("bad order");
  a_phase_lamp: assert property (s_pass(3'h1) |=>
    LAMPS == 3'h4) else $error("no pass lamp");
  a_all_off: assert property (s_pass(3'h5) |=> LAMPS == 3'h0)
    else $error("lamps not off");
  a_restart_test: assert property (s_restart |-> ##[1:3]
    TEST_REQ && TEST_ID == 3'h0) else $error("no restart");
  a_fault_lamps: assert property (go && FAULT_VALID && !CPU_HALT |=>
    LAMPS == 3'h7) else $error("fault not lit");
  a_fatal_hold: assert property (go && LAMPS == 3'h7 && !rs |=>
    LAMPS == 3'h7) else $error("fatal lost");
  a_halt_hold: assert property (go && CPU_HALT && !rs |=>
    CPU_HALT && $stable(LAMPS)) else $error("halt lost");
  a_rd_fatal: assert property (go && REG_ACCESS.rd &&
    REG_ACCESS.offset == 4'h2 |=> REG_RDATA[15] == $past(ft))
    else $error("fatal bit wrong");
  a_rd_other: assert property (go && REG_ACCESS.rd &&
    REG_ACCESS.offset != 4'h2 |=> REG_RDATA == 16'h0000)
    else $error("unmapped read");
  a_rdata_hold: assert property (go && !REG_ACCESS.rd |=>
    $stable(REG_RDATA)) else $error("read data moved");
endmodule : selftest_chk
bind selftest_fault_reporter selftest_chk u_selftest_chk (.MCLK, .RST_B,
  .BUS_INIT, .REG_ACCESS, .TEST_RESULT, .FAULT_VALID, .REG_RDATA,
  .TEST_REQ, .TEST_ID, .LAMPS, .CPU_HALT);

// File: bench/test_engine_model.sv
// Behavioural test engine answering the block's test requests.
`timescale 1ns/100ps
module test_engine_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Request and the verdict to give.
  input wire logic req,
  input wire selftest_pkg::test_id_e id,
  input wire logic [2:0] fail_id,
  input wire logic [3:0] delay,
  // Answer to the block.
  output selftest_pkg::test_result_s result
);
  logic busy;
  logic bad;
  logic [3:0] cnt;
  // Waits the delay, then pulses done; fail toggles while not valid.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      bad <= 1'b0;
      cnt <= 4'h0;
      result <= '0;
    end else begin
      result <= '{done: 1'b0, fail: ~result.fail};
      if (req) begin
        busy <= 1'b1;
        cnt <= delay;
        bad <= (id == fail_id);
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        result <= '{done: 1'b1, fail: bad};
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : test_engine_model

// File: bench/test_selftest_fault_reporter.sv
// Self-checking bench for the self-test reporter.
`timescale 1ns/100ps
`include "selftest_consts.svh"
module test_selftest_fault_reporter;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic bus_init = 1'b0;
  logic diag = 1'b0;
  logic host_init = 1'b0;
  logic fault_valid = 1'b0;
  logic [2:0] fail_id = 3'h7;
  logic [3:0] dly = 4'h9;
  logic [15:0] rdata;
  logic [15:0] got;
  logic req;
  logic halt;
  logic [2:0] lamps;
  selftest_pkg::reg_access_s acc = '0;
  selftest_pkg::test_id_e test_id;
  selftest_pkg::test_result_s result;
  selftest_pkg::fault_kind_e kind = selftest_pkg::FK_NO_INFO;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] codes [11] = '{`CODE_NO_INFO, `CODE_PKT_READ, `CODE_PKT_WRITE,
    `CODE_RING_READ, `CODE_RING_WRITE, `CODE_HOST_TIMEOUT, `CODE_CMD_OVERFLOW,
    `CODE_DMA_FAIL, `CODE_BAD_CONN_ID, `CODE_INIT_SEQ, `CODE_CTRL_FATAL};
  logic [2:0] f_lamps [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h3, 3'h6};
  logic [7:0] f_codes [6] = '{8'h0c, 8'h0c, 8'h04, 8'h0c, 8'h04, 8'h05};
  // The block and its test engine.
  selftest_fault_reporter u_selftest_fault_reporter (.MCLK(mclk),
    .RST_B(rst_b), .BUS_INIT(bus_init), .DIAG_DISPLAY_SWITCH(diag),
    .REG_ACCESS(acc), .REG_RDATA(rdata), .HOST_INIT_START(host_init),
    .TEST_REQ(req), .TEST_ID(test_id), .TEST_RESULT(result),
    .FAULT_VALID(fault_valid), .FAULT_KIND(kind), .LAMPS(lamps),
    .CPU_HALT(halt));
  test_engine_model u_test_engine_model (.clk(mclk), .rst_b(rst_b),
    .req(req), .id(test_id), .fail_id(fail_id), .delay(dly),
    .result(result));
  // A 4 ns clock.
  always #2 mclk = ~mclk;
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // One word access held over one rising edge; read data lands in got.
  task reg_op(input logic wr, input logic [3:0] off, input logic [15:0] wd);
    @(negedge mclk);
    acc = '{wr: wr, rd: !wr, offset: off, wdata: wd};
    @(negedge mclk);
    acc = '0;
    got = rdata;
  endtask : reg_op
  // Bounded wait for a lamp pattern.
  task wait_lamps(input logic [2:0] v);
    int n;
    for (n = 0; n < 400 && lamps !== v; n++) @(negedge mclk);
    if (n == 400) begin
      fails++;
      end_of_test();
    end
  endtask : wait_lamps
  task pulse_host_init;
    @(negedge mclk) host_init = 1'b1;
    @(negedge mclk) host_init = 1'b0;
  endtask : pulse_host_init
  task t_pass;
    wait_lamps(`LAMPS_PRETEST_PASS);
    reg_op(0, `PORT_STATUS_OFFSET, 0);
    check(got, 16'h4000);
    pulse_host_init();
    wait_lamps(`LAMPS_OFF);
    reg_op(0, `PORT_STATUS_OFFSET, 0);
    check(got, 16'h6000);
    reg_op(1, `PORT_STATUS_OFFSET, 16'hffff);
    reg_op(0, 4'h4, 0);
    check(got, 16'h0000);
    reg_op(0, `PORT_STATUS_OFFSET, 0);
    check(got, 16'h6000);
  endtask : t_pass
  task t_faults;
    dly = 4'h0;
    for (int k = 0; k < 11; k++) begin
      reg_op(1, `INIT_POLL_OFFSET, 16'(k));
      repeat (4) @(negedge mclk);
      kind = selftest_pkg::fault_kind_e'(k);
      fault_valid = 1'b1;
      @(negedge mclk);
      kind = selftest_pkg::fault_kind_e'((k + 1) % 11);
      @(negedge mclk);
      fault_valid = 1'b0;
      check(lamps, `LAMPS_FATAL);
      reg_op(0, `PORT_STATUS_OFFSET, 0);
      check(got[15], 1'b1);
      check(got[7:0], codes[k]);
    end
  endtask : t_faults
  task t_diag;
    diag = 1'b1;
    for (int t = 0; t < 6; t++) begin
      fail_id = 3'(t);
      @(negedge mclk) bus_init = 1'b1;
      @(negedge mclk) bus_init = 1'b0;
      if (t > 1) begin
        wait_lamps(`LAMPS_IDLE);
        pulse_host_init();
      end
      wait_lamps(f_lamps[t]);
      check(halt, 1'b1);
      repeat (5) @(negedge mclk);
      reg_op(0, `PORT_STATUS_OFFSET, 0);
      check(got[15], 1'b1);
      check(got[7:0], f_codes[t]);
      check(lamps, f_lamps[t]);
    end
  endtask : t_diag
  task t_off;
    diag = 1'b0;
    fail_id = 3'h4;
    reg_op(1, `INIT_POLL_OFFSET, 16'h0000);
    wait_lamps(`LAMPS_PRETEST_PASS);
    pulse_host_init();
    wait_lamps(`LAMPS_FATAL);
    check(halt, 1'b0);
    reg_op(0, `PORT_STATUS_OFFSET, 0);
    check(got, 16'hc000 | 16'(`CODE_CTRL_RAM));
  endtask : t_off
  // Reset for five cycles, then the scenarios.
  initial begin
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    t_pass();
    t_faults();
    t_diag();
    t_off();
    end_of_test();
  end
endmodule : test_selftest_fault_reporter
